// File: logic/wrf_pkg.sv
/*
  Shared constants, types and helpers for the windowed register file with
  load scoreboard. Assumes one processor clock and one asynchronous reset.
*/
package wrf_pkg;
  // ---------------------------------------------------------------
  // Sizes and fixed values
  // ---------------------------------------------------------------
  localparam int unsigned WRF_XLEN = 32;
  localparam int unsigned WRF_NGLB = 16;
  localparam int unsigned WRF_NLOC = 16;
  localparam int unsigned WRF_NSLOT = 4;
  localparam int unsigned WRF_NREG = 32;
  localparam int unsigned WRF_LOCAL_BIT = 4;
  localparam logic [3:0] WRF_FP_IDX = 4'hF;
  localparam logic [3:0] WRF_LAST_WORD = 4'hF;
  localparam logic [2:0] WRF_SLOTS_FULL = 3'h4;
  localparam logic [2:0] WRF_SLOTS_RST = 3'h1;
  localparam logic [1:0] WRF_LD_MAX = 2'h3;
  localparam logic [31:0] WRF_WORD_BYTES = 32'h4;
  localparam logic [31:0] WRF_FRAME_BYTES = 32'h40;
  localparam logic [31:0] WRF_REG_RST = 32'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [31:0] wrf_word_t;
  typedef logic [4:0] wrf_raddr_t;
  typedef logic [1:0] wrf_slot_t;
  typedef logic [3:0] wrf_widx_t;
  typedef logic [15:0] wrf_depth_t;

  typedef enum logic [2:0] {
    WRF_ST_IDLE = 3'b001,
    WRF_ST_SPILL = 3'b010,
    WRF_ST_FILL = 3'b100
  } wrf_state_t;

  // One instruction offered for issue
  typedef struct packed {
    logic valid;
    logic use_a;
    wrf_raddr_t src_a;
    logic use_b;
    wrf_raddr_t src_b;
    logic has_dst;
    wrf_raddr_t dst;
    logic is_load;
    logic is_cond;
    logic needs_cond;
  } wrf_issue_t;

  // One register write (ALU result or returning load)
  typedef struct packed {
    logic valid;
    wrf_raddr_t addr;
    wrf_word_t data;
  } wrf_wr_t;

  // Frame stack memory request
  typedef struct packed {
    logic req;
    logic we;
    wrf_word_t addr;
    wrf_word_t wdata;
  } wrf_mem_req_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic wrf_is_local(input wrf_raddr_t a);
    return a[WRF_LOCAL_BIT];
  endfunction

  // Byte address of one word of one stacked frame above the frame pointer
  function automatic wrf_word_t wrf_stack_addr(input wrf_word_t fp, input wrf_depth_t frm,
                                               input wrf_widx_t idx);
    return fp + ({16'h0, frm} * WRF_FRAME_BYTES) + ({28'h0, idx} * WRF_WORD_BYTES);
  endfunction
endpackage

// File: logic/wrf_scoreboard.sv
/*
  Load scoreboard: one busy bit per addressable register, a count of
  pending loads and a pending-condition flag. Assumes at most one load
  issues and one load returns per cycle.
*/
module wrf_scoreboard
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Updates
  input wire logic set_valid,
  input wire wrf_pkg::wrf_raddr_t set_addr,
  input wire logic clr_valid,
  input wire wrf_pkg::wrf_raddr_t clr_addr,
  input wire logic cond_set,
  input wire logic cond_clr,
  // Queries
  input wire wrf_pkg::wrf_raddr_t q_a,
  input wire wrf_pkg::wrf_raddr_t q_b,
  input wire wrf_pkg::wrf_raddr_t q_dst,
  output logic busy_a,
  output logic busy_b,
  output logic busy_dst,
  output logic full,
  output logic quiet,
  output logic cond_pend
);
  import wrf_pkg::*;

  logic [WRF_NREG-1:0] bits_q, bits_d; // Busy bit per register
  logic [1:0] cnt_q, cnt_d; // Loads in flight
  logic cond_q, cond_d; // Condition outstanding
  logic clr_hit; // Return matches a pending bit
  logic [WRF_NREG-1:0] set_vec, clr_vec;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // A return for a register with no bit set is ignored, not counted
  assign clr_hit = clr_valid & bits_q[clr_addr];
  assign set_vec = set_valid ? (WRF_NREG'(1) << set_addr) : '0;
  assign clr_vec = clr_hit ? (WRF_NREG'(1) << clr_addr) : '0;
  // Set applied after clear so a same-cycle set survives
  assign bits_d = (bits_q & ~clr_vec) | set_vec;
  assign cnt_d = 2'(cnt_q + {1'b0, set_valid} - {1'b0, clr_hit});
  assign cond_d = cond_set | (cond_q & ~cond_clr);

  // Queries
  assign busy_a = bits_q[q_a];
  assign busy_b = bits_q[q_b];
  assign busy_dst = bits_q[q_dst];
  assign full = (cnt_q == WRF_LD_MAX);
  assign quiet = (cnt_q == 2'h0);
  assign cond_pend = cond_q;

  // State
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bits_q <= '0;
      cnt_q <= 2'h0;
      cond_q <= 1'b0;
    end
    else if (ce)
    begin
      bits_q <= bits_d;
      cnt_q <= cnt_d;
      cond_q <= cond_d;
    end
  end
endmodule

// File: logic/wrf_frame_ctrl.sv
/*
  Frame cache sequencer: tracks the current slot, cached frame count and
  stacked frame depth, and steps spill and fill transfers word by word.
  Assumes the memory answers each request with a one-cycle ack.
*/
module wrf_frame_ctrl
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Commands
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic quiet,
  input wire logic mem_ack,
  // Status
  output wrf_pkg::wrf_state_t state,
  output wrf_pkg::wrf_slot_t cur_slot,
  output wrf_pkg::wrf_slot_t xfer_slot,
  output wrf_pkg::wrf_depth_t xfer_frame,
  output wrf_pkg::wrf_widx_t word_idx,
  output logic ready
);
  import wrf_pkg::*;

  wrf_state_t st_q, st_d;
  wrf_slot_t cur_q, cur_d, xs_q, xs_d;
  logic [2:0] cached_q, cached_d; // Frames resident, 1..4
  wrf_depth_t deep_q, deep_d; // Frames pushed to memory
  wrf_widx_t idx_q, idx_d;
  logic last_word;

  assign ready = (st_q == WRF_ST_IDLE) & quiet;
  assign last_word = mem_ack & (idx_q == WRF_LAST_WORD);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cur_d = cur_q;
    xs_d = xs_q;
    cached_d = cached_q;
    deep_d = deep_q;
    idx_d = idx_q;
    case (st_q)
      WRF_ST_IDLE:
      begin
        // Call wins if both arrive; frames only move with no load in flight
        if (call_req & quiet)
        begin
          if (cached_q == WRF_SLOTS_FULL)
          begin
            st_d = WRF_ST_SPILL;
            xs_d = cur_q + 2'h1;
            idx_d = 4'h0;
          end
          else
          begin
            cur_d = cur_q + 2'h1;
            cached_d = cached_q + 3'h1;
          end
        end
        else if (ret_req & quiet)
        begin
          if (cached_q > WRF_SLOTS_RST)
          begin
            cur_d = cur_q - 2'h1;
            cached_d = cached_q - 3'h1;
          end
          else if (deep_q != '0)
          begin
            st_d = WRF_ST_FILL;
            xs_d = cur_q - 2'h1;
            idx_d = 4'h0;
          end
        end
      end
      WRF_ST_SPILL:
      begin
        if (mem_ack)
          idx_d = idx_q + 4'h1;
        // Oldest slot now free: it becomes the callee's frame
        if (last_word)
        begin
          st_d = WRF_ST_IDLE;
          deep_d = deep_q + 16'h1;
          cur_d = xs_q;
        end
      end
      WRF_ST_FILL:
      begin
        if (mem_ack)
          idx_d = idx_q + 4'h1;
        if (last_word)
        begin
          st_d = WRF_ST_IDLE;
          deep_d = deep_q - 16'h1;
          cur_d = xs_q;
        end
      end
      default:
        st_d = WRF_ST_IDLE;
    endcase
  end

  // State
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= WRF_ST_IDLE;
      cur_q <= '0;
      xs_q <= '0;
      cached_q <= WRF_SLOTS_RST;
      deep_q <= '0;
      idx_q <= '0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cur_q <= cur_d;
      xs_q <= xs_d;
      cached_q <= cached_d;
      deep_q <= deep_d;
      idx_q <= idx_d;
    end
  end

  assign state = st_q;
  assign cur_slot = cur_q;
  assign xfer_slot = xs_q;
  assign xfer_frame = (st_q == WRF_ST_FILL) ? 16'(deep_q - 16'h1) : deep_q;
  assign word_idx = idx_q;
endmodule

// File: logic/wrf_top.sv
/*
  Windowed register file: sixteen global registers, a four-slot cache of
  sixteen-word local frames with spill and fill to a memory frame stack,
  a load scoreboard and ALU result bypass on the read ports.
  Assumes the pipeline holds an instruction while stall is high, holds a
  call or return request until frame_ready, and that memory acks each
  frame word in order.
*/
module wrf_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Instruction issue
  input wire wrf_pkg::wrf_issue_t iss,
  output logic iss_stall,
  output wrf_pkg::wrf_word_t rd_a_data,
  output wrf_pkg::wrf_word_t rd_b_data,
  // Result writes
  input wire wrf_pkg::wrf_wr_t alu_wr,
  input wire wrf_pkg::wrf_wr_t ld_ret,
  input wire logic cond_done,
  // Procedure linkage
  input wire logic call_req,
  input wire logic ret_req,
  output logic frame_ready,
  // Frame stack memory
  output wrf_pkg::wrf_mem_req_t mem,
  input wire logic mem_ack,
  input wire wrf_pkg::wrf_word_t mem_rdata,
  // Status
  output logic loads_full
);
  import wrf_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Global bank, never indexed by frame
  wrf_word_t glb_q [WRF_NGLB];
  // Local frame cache, one row per slot
  wrf_word_t loc_q [WRF_NSLOT][WRF_NLOC];
  // Registered read data
  wrf_word_t rd_a_q, rd_b_q;

  // ---------------------------------------------------------------
  // Sub-block wiring
  // ---------------------------------------------------------------
  wrf_state_t fst; // Sequencer state
  wrf_slot_t cur_slot; // Frame of running procedure
  wrf_slot_t xfer_slot; // Slot being spilled or filled
  wrf_depth_t xfer_frame; // Stack frame number in transfer
  wrf_widx_t word_idx; // Word within transfer
  logic busy_a, busy_b, busy_dst; // Scoreboard hits
  logic sb_full, sb_quiet, cond_pend;
  logic frame_busy; // Spill or fill in progress
  logic iss_fire; // Instruction accepted this cycle
  logic ld_fire; // Load accepted this cycle
  logic haz_src, haz_dst, haz_ld, haz_cond;
  logic fill_wr; // Memory word lands in cache
  wrf_word_t fp_val; // Frame stack base

  // ---------------------------------------------------------------
  // Read helper
  // ---------------------------------------------------------------
  // One address space of 32: bit 4 picks locals of the current frame.
  // Same-cycle writes are forwarded so an op dependent on an ALU result needs no extra cycle.
  function automatic wrf_word_t rf_value(input wrf_raddr_t a);
    wrf_word_t v;
    v = wrf_is_local(a) ? loc_q[cur_slot][a[3:0]] : glb_q[a[3:0]];
    if (alu_wr.valid && (alu_wr.addr == a))
      v = alu_wr.data;
    else if (ld_ret.valid && (ld_ret.addr == a))
      v = ld_ret.data;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Scoreboard
  // ---------------------------------------------------------------
  wrf_scoreboard u_sb
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .set_valid(ld_fire),
    .set_addr(iss.dst),
    .clr_valid(ld_ret.valid),
    .clr_addr(ld_ret.addr),
    .cond_set(iss_fire & iss.is_cond),
    .cond_clr(cond_done),
    .q_a(iss.src_a),
    .q_b(iss.src_b),
    .q_dst(iss.dst),
    .busy_a(busy_a),
    .busy_b(busy_b),
    .busy_dst(busy_dst),
    .full(sb_full),
    .quiet(sb_quiet),
    .cond_pend(cond_pend)
  );

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // Frames move only with no load in flight, but a load accepted in the cycle
  // a call or return is taken can return into the slot of the new frame.
  wrf_frame_ctrl u_fc
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .call_req(call_req),
    .ret_req(ret_req),
    .quiet(sb_quiet),
    .mem_ack(mem_ack),
    .state(fst),
    .cur_slot(cur_slot),
    .xfer_slot(xfer_slot),
    .xfer_frame(xfer_frame),
    .word_idx(word_idx),
    .ready(frame_ready)
  );

  assign frame_busy = (fst != WRF_ST_IDLE);

  // ---------------------------------------------------------------
  // Issue hazards
  // ---------------------------------------------------------------
  // Only the sources actually used are checked, so unrelated work flows
  assign haz_src = (iss.use_a & busy_a) | (iss.use_b & busy_b);
  // A pending load's target may not be overwritten out of order
  assign haz_dst = iss.has_dst & busy_dst;
  // No fourth load until an entry frees
  assign haz_ld = iss.is_load & sb_full;
  // Only instructions that consume the condition wait for it
  assign haz_cond = iss.needs_cond & cond_pend;
  // Locals are unstable while a frame moves
  assign iss_stall = iss.valid & (haz_src | haz_dst | haz_ld | haz_cond | frame_busy);
  assign iss_fire = iss.valid & ~iss_stall;
  assign ld_fire = iss_fire & iss.is_load & iss.has_dst;
  assign loads_full = sb_full;

  // ---------------------------------------------------------------
  // Frame stack memory port
  // ---------------------------------------------------------------
  // Base comes from the last global, read but never rewritten here
  assign fp_val = glb_q[WRF_FP_IDX];
  assign mem.req = frame_busy;
  assign mem.we = (fst == WRF_ST_SPILL);
  assign mem.addr = wrf_stack_addr(fp_val, xfer_frame, word_idx);
  assign mem.wdata = loc_q[xfer_slot][word_idx];
  assign fill_wr = (fst == WRF_ST_FILL) & mem_ack;

  // ---------------------------------------------------------------
  // Global bank writes
  // ---------------------------------------------------------------
  // Only program results land here; spill and fill never do
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < WRF_NGLB; i++)
        glb_q[i] <= WRF_REG_RST;
    end
    else if (ce)
    begin
      if (alu_wr.valid & ~wrf_is_local(alu_wr.addr))
        glb_q[alu_wr.addr[3:0]] <= alu_wr.data;
      if (ld_ret.valid & ~wrf_is_local(ld_ret.addr))
        glb_q[ld_ret.addr[3:0]] <= ld_ret.data;
    end
  end

  // ---------------------------------------------------------------
  // Local frame cache writes
  // ---------------------------------------------------------------
  // Program writes go to the current slot; a fill targets another slot,
  // so the two ports never collide.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int s = 0; s < WRF_NSLOT; s++)
        for (int i = 0; i < WRF_NLOC; i++)
          loc_q[s][i] <= WRF_REG_RST;
    end
    else if (ce)
    begin
      if (alu_wr.valid & wrf_is_local(alu_wr.addr))
        loc_q[cur_slot][alu_wr.addr[3:0]] <= alu_wr.data;
      if (ld_ret.valid & wrf_is_local(ld_ret.addr))
        loc_q[cur_slot][ld_ret.addr[3:0]] <= ld_ret.data;
      if (fill_wr)
        loc_q[xfer_slot][word_idx] <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Read ports
  // ---------------------------------------------------------------
  // Operands are captured when the instruction is accepted and held
  // until the next accepted instruction.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_a_q <= WRF_REG_RST;
      rd_b_q <= WRF_REG_RST;
    end
    else if (ce & iss_fire)
    begin
      rd_a_q <= rf_value(iss.src_a);
      rd_b_q <= rf_value(iss.src_b);
    end
  end

  assign rd_a_data = rd_a_q;
  assign rd_b_data = rd_b_q;
endmodule

// File: verification/wrf_top_properties.sv
/*
  Concurrent checks on the register file ports.
  Assumes it is bound to every instance of wrf_top.
*/
module wrf_top_properties
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Issue and results
  input wire wrf_pkg::wrf_issue_t iss,
  input wire logic iss_stall,
  input wire wrf_pkg::wrf_word_t rd_a_data,
  input wire wrf_pkg::wrf_word_t rd_b_data,
  input wire wrf_pkg::wrf_wr_t alu_wr,
  input wire wrf_pkg::wrf_wr_t ld_ret,
  input wire logic cond_done,
  // Linkage and frame memory
  input wire logic call_req,
  input wire logic ret_req,
  input wire logic frame_ready,
  input wire wrf_pkg::wrf_mem_req_t mem,
  input wire logic mem_ack,
  input wire wrf_pkg::wrf_word_t mem_rdata,
  input wire logic loads_full
);
  timeunit 1ns;
  timeprecision 1ns;
  import wrf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Instruction taken at this edge
  wire logic take = ce && iss.valid && !iss_stall;
  // Scoreboard full refuses another load
  property p_load_cap; loads_full && iss.valid && iss.is_load |-> iss_stall; endproperty
  a_load_cap: assert property (p_load_cap)
    else $error("load taken with three pending");
  // Reader of a just-loaded register waits
  property p_load_busy;
    take && iss.is_load && iss.has_dst ##1 iss.valid && iss.use_a && iss.src_a == $past(iss.dst)
      |-> iss_stall;
  endproperty
  a_load_busy: assert property (p_load_busy)
    else $error("reader of pending load not held");
  // Condition consumer waits for the condition
  property p_cond_wait; take && iss.is_cond ##1 iss.valid && iss.needs_cond |-> iss_stall; endproperty
  a_cond_wait: assert property (p_cond_wait)
    else $error("condition consumer not held");
  // Hazard-free instruction never waits outside frame moves
  property p_free_issue;
    iss.valid && !iss.use_a && !iss.use_b && !iss.has_dst && !iss.is_load && !iss.needs_cond
      && !mem.req |-> !iss_stall;
  endproperty
  a_free_issue: assert property (p_free_issue)
    else $error("unrelated instruction held");
  // Frame moves hold the pipeline
  property p_xfer_stall; mem.req && iss.valid |-> iss_stall; endproperty
  a_xfer_stall: assert property (p_xfer_stall)
    else $error("issue during frame move");
  // ALU result bypassed to a reader in the same cycle
  property p_bypass;
    take && alu_wr.valid && iss.use_a && iss.src_a == alu_wr.addr |=> rd_a_data == $past(alu_wr.data);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass value wrong");
  // Each acknowledged word moves one word up the stack
  property p_word_step; mem.req && mem_ack && ce ##1 mem.req |-> mem.addr == $past(mem.addr) + 32'h4;
  endproperty
  a_word_step: assert property (p_word_step)
    else $error("frame word address step wrong");
  // A waiting word request stays put
  property p_word_hold; mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.we);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("frame request changed before ack");
  // Ready means no transfer and no full scoreboard
  property p_ready_quiet; frame_ready |-> !mem.req && !loads_full; endproperty
  a_ready_quiet: assert property (p_ready_quiet)
    else $error("ready during transfer or pending loads");
endmodule

bind wrf_top wrf_top_properties chk_u (.clk(clk), .rst(rst), .ce(ce), .iss(iss),
  .iss_stall(iss_stall), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .alu_wr(alu_wr),
  .ld_ret(ld_ret), .cond_done(cond_done), .call_req(call_req), .ret_req(ret_req),
  .frame_ready(frame_ready), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .loads_full(loads_full));

// File: verification/wrf_mem_model.sv
/*
  Frame stack memory model with a settable wait per word.
  Assumes requests hold until acked; data changes each idle cycle.
*/
module wrf_mem_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame stack port
  input wire wrf_pkg::wrf_mem_req_t mem,
  output logic mem_ack,
  output wrf_pkg::wrf_word_t mem_rdata,
  // Wait cycles before each ack
  input wire logic [3:0] slow
);
  timeunit 1ns;
  timeprecision 1ns;
  import wrf_pkg::*;
  wrf_word_t store [wrf_word_t]; // Sparse stack image
  int wcnt; // Cycles waited on the current word
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wcnt = 0;
  end
  // Answer just after the edge; unused data flips so a stale read shows
  always @(posedge clk)
  begin
    #1;
    if (rst || !mem.req)
    begin
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
      wcnt = 0;
    end
    else if (wcnt >= slow)
    begin
      mem_ack = 1'b1;
      wcnt = 0;
      if (mem.we)
        store[mem.addr] = mem.wdata;
      mem_rdata = store.exists(mem.addr) ? store[mem.addr] : ~mem_rdata;
    end
    else
    begin
      mem_ack = 1'b0;
      wcnt++;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule

// File: verification/tb.sv
/*
  Self-checking bench for the windowed register file.
  Assumes the memory model and the bound checker are compiled first.
*/
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wrf_pkg::*;
  typedef struct {bit ua; bit ub; wrf_word_t a; wrf_word_t b;} wrf_tb_exp_t;
  logic clk, rst, ce, cond_done, call_req, ret_req, iss_stall, frame_ready, mem_ack, loads_full;
  wrf_issue_t iss;
  wrf_wr_t alu_wr, ld_ret;
  wrf_word_t rd_a_data, rd_b_data, mem_rdata;
  wrf_mem_req_t mem;
  logic [3:0] slow; // Memory wait per word
  int failures, total_checks, mreq, n;
  wrf_word_t glb [16]; // Expected globals
  wrf_word_t lv [8][16]; // Expected locals per call level
  int lvl;
  wrf_tb_exp_t q[$]; // Operands noted at issue
  wrf_tb_exp_t e;
  wrf_top dut_u (.clk(clk), .rst(rst), .ce(ce), .iss(iss), .iss_stall(iss_stall),
    .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .alu_wr(alu_wr), .ld_ret(ld_ret),
    .cond_done(cond_done), .call_req(call_req), .ret_req(ret_req), .frame_ready(frame_ready),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .loads_full(loads_full));
  wrf_mem_model mem_u (.clk(clk), .rst(rst), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .slow(slow));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic wrf_word_t val(input wrf_raddr_t a);
    return a[4] ? lv[lvl][a[3:0]] : glb[a[3:0]];
  endfunction
  function automatic void put(input wrf_raddr_t a, input wrf_word_t d);
    if (a[4])
      lv[lvl][a[3:0]] = d;
    else
      glb[a[3:0]] = d;
  endfunction
  // Read a and ~a, or load into a; cn selects set or wait on condition
  function automatic wrf_issue_t op(input logic ua, input wrf_raddr_t a, input logic ld,
                                    input logic [1:0] cn);
    return '{1'b1, ua, a, ua, ~a, ld, a, ld, cn[0], cn[1]};
  endfunction
  task automatic idle();
    @(negedge clk);
    iss = '0;
    alu_wr = '0;
    ld_ret = '0;
    cond_done = 1'b0;
  endtask
  // Offer an instruction, wait until taken, note expected operands
  task automatic issue(input wrf_issue_t i, input wrf_wr_t w, output int k);
    k = 0;
    @(negedge clk);
    iss = i;
    alu_wr = w;
    ld_ret = '0;
    cond_done = 1'b0;
    if (w.valid)
      put(w.addr, w.data);
    #1;
    while (iss_stall !== 1'b0 && k < 400)
    begin
      @(negedge clk);
      #1;
      k++;
    end
    if (k == 400)
      failures++;
    q.push_back('{i.use_a, i.use_b, val(i.src_a), val(i.src_b)});
  endtask
  // Offer an instruction that must be held for three cycles
  task automatic try(input wrf_issue_t i);
    @(negedge clk);
    iss = i;
    ld_ret = '0;
    cond_done = 1'b0;
    repeat (3)
    begin
      #1;
      `CHK("iss_stall", 1'b1, iss_stall)
      @(negedge clk);
    end
  endtask
  task automatic wr(input wrf_raddr_t a, input wrf_word_t d);
    @(negedge clk);
    alu_wr = '{1'b1, a, d};
    put(a, d);
  endtask
  task automatic ldret(input wrf_raddr_t a);
    @(negedge clk);
    ld_ret = '{1'b1, a, $urandom};
    put(a, ld_ret.data);
  endtask
  task automatic wrloc();
    for (int k = 0; k < 16; k++)
      wr({1'b1, k[3:0]}, $urandom);
    idle();
  endtask
  task automatic rdall();
    for (int k = 0; k < 32; k++)
      issue(op(1'b1, k[4:0], 1'b0, 2'h0), '0, n);
    idle();
  endtask
  // Call or return; held until the sequencer takes it
  task automatic frame(input logic c);
    int k;
    k = 0;
    @(negedge clk);
    call_req = c;
    ret_req = !c;
    #1;
    while (frame_ready !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      #1;
      k++;
    end
    if (k == 400)
      failures++;
    @(negedge clk);
    call_req = 1'b0;
    ret_req = 1'b0;
    lvl = c ? lvl + 1 : lvl - 1;
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Monitor: read data the cycle after each accepted instruction
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst && ce && iss.valid && iss_stall === 1'b0)
    begin
      @(negedge clk);
      e = q.pop_front();
      if (e.ua)
        `CHK("rd_a_data", e.a, rd_a_data)
      if (e.ub)
        `CHK("rd_b_data", e.b, rd_b_data)
    end
  end
  // Cycles with a frame stack request up
  always @(posedge clk)
    if (mem.req === 1'b1)
      mreq++;
  // Hang guard, far beyond the expected few hundred cycles
  initial
  begin
    #2000000;
    failures++;
    conclude();
  end
  initial
  begin
    iss = '0;
    alu_wr = '0;
    ld_ret = '0;
    cond_done = 1'b0;
    call_req = 1'b0;
    ret_req = 1'b0;
    ce = 1'b1;
    slow = 4'h0;
    rst = 1'b1;
    lvl = 0;
    void'($urandom(53805));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 32; k++)
      wr(k[4:0], $urandom);
    wr(5'h0F, $urandom & 32'hFFFF_FF00);
    idle();
    rdall();
    issue(op(1'b1, 5'h05, 1'b0, 2'h0), '{1'b1, 5'h05, $urandom}, n);
    idle();
    $display("Test registers and bypass done");
    for (int k = 0; k < 3; k++)
      issue(op(1'b0, 5'h14 + k[4:0], 1'b1, 2'h0), '0, n);
    try(op(1'b1, 5'h16, 1'b0, 2'h0));
    ldret(5'h16);
    issue(op(1'b1, 5'h16, 1'b0, 2'h0), '0, n);
    issue(op(1'b1, 5'h01, 1'b0, 2'h0), '0, n);
    `CHK("wait cycles", 0, n)
    issue(op(1'b0, 5'h17, 1'b1, 2'h0), '0, n);
    idle();
    #1;
    `CHK("loads_full", 1'b1, loads_full)
    try(op(1'b0, 5'h18, 1'b1, 2'h0));
    ldret(5'h14);
    issue(op(1'b0, 5'h18, 1'b1, 2'h0), '0, n);
    ldret(5'h15);
    ldret(5'h17);
    ldret(5'h18);
    idle();
    #1;
    `CHK("loads_full", 1'b0, loads_full)
    rdall();
    $display("Test load scoreboard done");
    issue(op(1'b0, 5'h00, 1'b0, 2'h1), '0, n);
    try(op(1'b1, 5'h02, 1'b0, 2'h2));
    @(negedge clk);
    cond_done = 1'b1;
    issue(op(1'b1, 5'h02, 1'b0, 2'h2), '0, n);
    idle();
    $display("Test condition done");
    mreq = 0;
    for (int k = 0; k < 4; k++)
    begin
      wrloc();
      if (k == 3)
        `CHK("req cycles", 0, mreq)
      frame(1'b1);
    end
    lv[4] = lv[0]; // Reused slot still holds the spilled words
    issue(op(1'b1, 5'h0F, 1'b0, 2'h0), '0, n);
    idle();
    `CHK("req cycles", 16, mreq)
    for (int k = 0; k < 16; k++)
      `CHK("stack word", lv[0][k], mem_u.store[glb[15] + wrf_word_t'(k * 4)])
    wrloc();
    rdall();
    ce = 1'b0; // Frozen: this write must not land
    wr(5'h03, ~glb[3]);
    idle();
    glb[3] = ~glb[3];
    ce = 1'b1;
    slow = 4'h2;
    repeat (4)
    begin
      frame(1'b0);
      rdall();
    end
    `CHK("req cycles", 64, mreq)
    $display("Test frames done");
    conclude();
  end
endmodule
